// ---- pkg/masc_consts.svh ----
// Register offsets, field positions, reset values and bus constants for the monitor converter control
`ifndef MASC_CONSTS_SVH
`define MASC_CONSTS_SVH
`define MASC_OFS_RESULT_HIGH 8'h07
`define MASC_OFS_RESULT_LOW 8'h08
`define MASC_OFS_CONTROL 8'h09
`define MASC_OFS_CHANNEL 8'h0a
`define MASC_CTL_GO_BIT 0
`define MASC_CTL_SINGLE_BIT 1
`define MASC_CTL_SCAN_BIT 2
`define MASC_CTL_BUFDIS_BIT 3
`define MASC_CHS_CONV_LSB 0
`define MASC_CHS_READ_LSB 3
`define MASC_CHS_READY_BIT 7
`define MASC_CTL_RESET 8'h00
`define MASC_CHS_RESET 8'h00
`define MASC_RESULT_RESET 12'h000
`define MASC_PTR_RESET 8'h00
`define MASC_LAST_CHANNEL 3'h6
`define MASC_I2C_ADDR 7'h5a
`define MASC_BITS_PER_BYTE 4'h8
`endif

// ---- pkg/masc_pkg.sv ----
// Types shared by the monitor converter control modules
package masc_pkg;
  typedef logic [2:0] masc_chan_t;
  typedef logic [11:0] masc_result_t;
  typedef enum logic [2:0]
  {
    MASC_I2C_IDLE = 3'b000,
    MASC_I2C_ADDR = 3'b001,
    MASC_I2C_ADDR_ACK = 3'b010,
    MASC_I2C_WR_BYTE = 3'b011,
    MASC_I2C_WR_ACK = 3'b100,
    MASC_I2C_RD_BYTE = 3'b101,
    MASC_I2C_RD_ACK = 3'b110
  } masc_i2c_state_t;
  typedef enum logic [1:0]
  {
    MASC_SEQ_IDLE = 2'b00,
    MASC_SEQ_CONV = 2'b01
  } masc_seq_state_t;
endpackage

// ---- rtl/masc_conv_seq.sv ----
// Conversion sequencer: drives the converter front end for single and scan conversions
`timescale 1ns/1ns
`include "masc_consts.svh"
module masc_conv_seq
  import masc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control from the register file
  input wire logic start_single,
  input wire logic scan_run,
  input wire masc_pkg::masc_chan_t conv_channel,
  // Converter front end
  output logic adc_start,
  output masc_pkg::masc_chan_t adc_mux_sel,
  input wire masc_pkg::masc_result_t adc_data,
  input wire logic adc_data_valid,
  // Results
  output logic busy,
  output logic result_we,
  output masc_pkg::masc_chan_t result_ch,
  output masc_pkg::masc_result_t result_data,
  output logic single_done,
  output logic scan_done
);
  import masc_pkg::*;

  masc_seq_state_t state_reg, state_next;
  logic single_reg, single_next;
  logic start_reg, start_next;
  masc_chan_t ch_reg, ch_next;
  logic we_reg, we_next;
  masc_result_t data_reg, data_next;
  logic sdone_reg, sdone_next;
  logic scdone_reg, scdone_next;

  always_comb
  begin
    state_next = state_reg;
    single_next = single_reg;
    start_next = 1'b0;
    ch_next = ch_reg;
    we_next = 1'b0;
    data_next = data_reg;
    sdone_next = 1'b0;
    scdone_next = 1'b0;
    case (state_reg)
      MASC_SEQ_IDLE:
      begin
        if (start_single)
        begin
          ch_next = conv_channel; // [R7]
          single_next = 1'b1;
          start_next = 1'b1; // [R9]
          state_next = MASC_SEQ_CONV;
        end
        else if (scan_run)
        begin
          ch_next = 3'h0; // [R5]
          single_next = 1'b0;
          start_next = 1'b1;
          state_next = MASC_SEQ_CONV;
        end
      end
      MASC_SEQ_CONV:
      begin
        // New start requests are not looked at here [R14]
        if (adc_data_valid)
        begin
          we_next = (ch_reg <= `MASC_LAST_CHANNEL); // [R2]
          data_next = adc_data; // [R1]
          if (single_reg)
          begin
            sdone_next = 1'b1; // [R10]
            state_next = MASC_SEQ_IDLE;
          end
          else
          begin
            scdone_next = (ch_reg == `MASC_LAST_CHANNEL);
            ch_next = (ch_reg >= `MASC_LAST_CHANNEL) ? 3'h0 : ch_reg + 3'h1; // [R5]
            if (scan_run)
            begin
              start_next = 1'b1;
            end
            else
            begin
              state_next = MASC_SEQ_IDLE;
            end
          end
        end
      end
      default:
      begin
        state_next = MASC_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= MASC_SEQ_IDLE;
      single_reg <= 1'b0;
      start_reg <= 1'b0;
      ch_reg <= 3'h0;
      we_reg <= 1'b0;
      data_reg <= `MASC_RESULT_RESET;
      sdone_reg <= 1'b0;
      scdone_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      single_reg <= single_next;
      start_reg <= start_next;
      ch_reg <= ch_next;
      we_reg <= we_next;
      data_reg <= data_next;
      sdone_reg <= sdone_next;
      scdone_reg <= scdone_next;
    end
  end

  // Result channel lags the mux by one cycle after a scan step
  masc_chan_t wch_reg;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wch_reg <= 3'h0;
    end
    else
    begin
      wch_reg <= ch_reg;
    end
  end

  assign adc_start = start_reg;
  assign adc_mux_sel = ch_reg; // [R1]
  assign busy = (state_reg != MASC_SEQ_IDLE);
  assign result_we = we_reg;
  assign result_ch = wch_reg;
  assign result_data = data_reg;
  assign single_done = sdone_reg;
  assign scan_done = scdone_reg;
endmodule

// ---- rtl/masc_top.sv ----
// Monitor converter control: two-wire register slave, result store and sequencer
//
// Summary of operation
// (R1) One 12-bit converter samples one of seven channels chosen by its input mux.
// (R2) Each of the seven channels keeps its own latest result.
// (R3) One of the seven results is routed into the register map by the readback select.
// (R4) The go bit of the control register at 0x09 enables converter operation.
// (R5) Conversions run either as a single manual shot or as an automatic scan of all channels.
// (R6) For single shots the host sets single mode, clears scan mode and clears buffer disable.
// (R7) The 3-bit convert select in register 0x0a picks the channel of the next single shot.
// (R8) The host sets the readback select equal to the convert select before a single shot.
// (R9) Writing 1 to the go bit starts a single conversion on that write.
// (R10) A finished single shot sets the ready flag, pulls the interrupt low and clears go.
// (R11) Result bits 11 to 4 sit in register 0x07 and bits 3 to 0 in register 0x08.
// (R12) Interrupt and ready stay asserted until the host reads the result, which releases them.
// (R13) For another channel the host updates both selects first, then writes go.
// (R14) A go write during a running conversion is ignored and the conversion completes.
`timescale 1ns/1ns
`include "masc_consts.svh"
module masc_top
  import masc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Two-wire bus pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Host interrupt
  output logic interrupt_request_n,
  // Converter front end
  output logic adc_enable,
  output logic input_buffer_disable,
  output logic adc_start,
  output masc_pkg::masc_chan_t adc_mux_sel,
  input wire masc_pkg::masc_result_t adc_data,
  input wire logic adc_data_valid
);
  import masc_pkg::*;

  function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] ctl, input logic [7:0] chs,
                                          input masc_result_t res);
    case (ofs)
      `MASC_OFS_RESULT_HIGH: reg_read = res[11:4]; // [R11]
      `MASC_OFS_RESULT_LOW: reg_read = {4'h0, res[3:0]}; // [R11]
      `MASC_OFS_CONTROL: reg_read = {4'h0, ctl[3:0]};
      `MASC_OFS_CHANNEL: reg_read = chs;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Pin synchronisers and edge history
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  logic bus_start, bus_stop, scl_rise, scl_fall;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;

  // Register state
  logic [7:0] ctl_reg, ctl_next;
  masc_chan_t conv_sel_reg, conv_sel_next;
  masc_chan_t read_sel_reg, read_sel_next;
  logic ready_reg, ready_next;
  logic irq_reg, irq_next;
  masc_result_t result_mem [0:6];
  masc_result_t result_mem_next [0:6];
  masc_result_t shown_result;

  // Bus slave state
  masc_i2c_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic first_reg, first_next;
  logic rw_reg, rw_next;
  logic drive_reg, drive_next;
  logic wr_stb, rd_stb;
  logic [7:0] wr_ofs;
  logic [7:0] wr_data;

  // Sequencer links
  logic busy, result_we, single_done, scan_done, start_single, scan_run;
  masc_chan_t result_ch;
  masc_result_t result_data;

  assign shown_result = (read_sel_reg <= `MASC_LAST_CHANNEL) ? result_mem[read_sel_reg] : `MASC_RESULT_RESET; // [R3]

  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    first_next = first_reg;
    rw_next = rw_reg;
    drive_next = drive_reg;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_ofs = ptr_reg;
    wr_data = sh_reg;
    if (bus_start)
    begin
      st_next = MASC_I2C_ADDR;
      cnt_next = 4'h0;
      drive_next = 1'b0;
    end
    else if (bus_stop)
    begin
      st_next = MASC_I2C_IDLE;
      drive_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        MASC_I2C_IDLE:
        begin
          drive_next = 1'b0;
        end
        MASC_I2C_ADDR, MASC_I2C_WR_BYTE:
        begin
          if (scl_rise && cnt_reg != `MASC_BITS_PER_BYTE)
          begin
            sh_next = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == `MASC_BITS_PER_BYTE)
          begin
            cnt_next = 4'h0;
            if (st_reg == MASC_I2C_ADDR)
            begin
              rw_next = sh_reg[0];
              first_next = 1'b1;
              drive_next = (sh_reg[7:1] == `MASC_I2C_ADDR);
              st_next = (sh_reg[7:1] == `MASC_I2C_ADDR) ? MASC_I2C_ADDR_ACK : MASC_I2C_IDLE;
            end
            else
            begin
              drive_next = 1'b1;
              st_next = MASC_I2C_WR_ACK;
              first_next = 1'b0;
              if (first_reg)
              begin
                ptr_next = sh_reg;
              end
              else
              begin
                wr_stb = 1'b1;
                ptr_next = ptr_reg + 8'h01;
              end
            end
          end
        end
        MASC_I2C_ADDR_ACK, MASC_I2C_WR_ACK, MASC_I2C_RD_ACK:
        begin
          if (st_reg == MASC_I2C_RD_ACK && scl_rise && sda_s)
          begin
            st_next = MASC_I2C_IDLE;
          end
          else if (scl_fall)
          begin
            if (st_reg == MASC_I2C_WR_ACK || (st_reg == MASC_I2C_ADDR_ACK && !rw_reg))
            begin
              drive_next = 1'b0;
              st_next = MASC_I2C_WR_BYTE;
            end
            else
            begin
              sh_next = reg_read(ptr_reg, ctl_reg, {ready_reg, 1'b0, read_sel_reg, conv_sel_reg}, shown_result);
              rd_stb = 1'b1;
              ptr_next = ptr_reg + 8'h01;
              drive_next = ~sh_next[7];
              st_next = MASC_I2C_RD_BYTE;
            end
          end
        end
        MASC_I2C_RD_BYTE:
        begin
          if (scl_rise)
          begin
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_reg == `MASC_BITS_PER_BYTE)
            begin
              cnt_next = 4'h0;
              drive_next = 1'b0;
              st_next = MASC_I2C_RD_ACK;
            end
            else
            begin
              sh_next = {sh_reg[6:0], 1'b0};
              drive_next = ~sh_reg[6];
            end
          end
        end
        default:
        begin
          st_next = MASC_I2C_IDLE;
        end
      endcase
    end
  end

  // Register file next values
  always_comb
  begin
    ctl_next = ctl_reg;
    conv_sel_next = conv_sel_reg;
    read_sel_next = read_sel_reg;
    ready_next = ready_reg;
    irq_next = irq_reg;
    start_single = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      result_mem_next[i] = result_mem[i];
    end
    if (result_we)
    begin
      result_mem_next[result_ch] = result_data; // [R2]
    end
    if (single_done)
    begin
      ctl_next[`MASC_CTL_GO_BIT] = 1'b0; // [R10]
    end
    if (rd_stb && (ptr_reg == `MASC_OFS_RESULT_HIGH || ptr_reg == `MASC_OFS_RESULT_LOW))
    begin
      ready_next = 1'b0; // [R12]
      irq_next = 1'b0; // [R12]
    end
    if (wr_stb && wr_ofs == `MASC_OFS_CONTROL)
    begin
      ctl_next = {4'h0, wr_data[3:0]}; // [R4]
      start_single = wr_data[`MASC_CTL_GO_BIT] & wr_data[`MASC_CTL_SINGLE_BIT] & ~wr_data[`MASC_CTL_SCAN_BIT] & ~busy; // [R9] [R14]
    end
    if (wr_stb && wr_ofs == `MASC_OFS_CHANNEL)
    begin
      conv_sel_next = wr_data[`MASC_CHS_CONV_LSB +: 3]; // [R7]
      read_sel_next = wr_data[`MASC_CHS_READ_LSB +: 3];
    end
    if (single_done)
    begin
      ready_next = 1'b1; // [R10]
      irq_next = 1'b1; // [R10]
    end
    if (scan_done)
    begin
      ready_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= MASC_I2C_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= `MASC_PTR_RESET;
      first_reg <= 1'b0;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
      ctl_reg <= `MASC_CTL_RESET;
      conv_sel_reg <= 3'h0;
      read_sel_reg <= 3'h0;
      ready_reg <= 1'b0;
      irq_reg <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
        result_mem[i] <= `MASC_RESULT_RESET;
      end
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      first_reg <= first_next;
      rw_reg <= rw_next;
      drive_reg <= drive_next;
      ctl_reg <= ctl_next;
      conv_sel_reg <= conv_sel_next;
      read_sel_reg <= read_sel_next;
      ready_reg <= ready_next;
      irq_reg <= irq_next;
      for (int i = 0; i < 7; i++)
      begin
        result_mem[i] <= result_mem_next[i];
      end
    end
  end

  // Scan runs while go is set in scan mode with single mode clear
  // Next control value, so a go clear landing with a result blocks the restart
  assign scan_run = ctl_next[`MASC_CTL_GO_BIT] & ctl_next[`MASC_CTL_SCAN_BIT] & ~ctl_next[`MASC_CTL_SINGLE_BIT]; // [R5]

  masc_conv_seq u_seq
  (
    .core_clk(core_clk),
    .rst(rst),
    .start_single(start_single),
    .scan_run(scan_run),
    .conv_channel(conv_sel_reg),
    .adc_start(adc_start),
    .adc_mux_sel(adc_mux_sel),
    .adc_data(adc_data),
    .adc_data_valid(adc_data_valid),
    .busy(busy),
    .result_we(result_we),
    .result_ch(result_ch),
    .result_data(result_data),
    .single_done(single_done),
    .scan_done(scan_done)
  );

  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_reg;
  assign interrupt_request_n = ~irq_reg; // [R12]
  assign adc_enable = ctl_reg[`MASC_CTL_GO_BIT]; // [R4]
  assign input_buffer_disable = ctl_reg[`MASC_CTL_BUFDIS_BIT];
endmodule

// ---- testbench/masc_top_properties.sv ----
// Port checks for the monitor converter control
`timescale 1ns/1ns
module masc_top_properties
  import masc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Interrupt and front end
  input wire logic interrupt_request_n,
  input wire logic adc_enable,
  input wire logic input_buffer_disable,
  input wire logic adc_start,
  input wire masc_pkg::masc_chan_t adc_mux_sel,
  input wire masc_pkg::masc_result_t adc_data,
  input wire logic adc_data_valid
);
  import masc_pkg::*;
  logic open_reg;
  logic open_next;
  masc_chan_t last_reg;
  masc_chan_t last_next;
  // Conversion in flight and channel of the latest start
  always_comb
  begin
    open_next = open_reg;
    last_next = last_reg;
    if (adc_start)
    begin
      open_next = 1'b1;
      last_next = adc_mux_sel;
    end
    else if (adc_data_valid)
      open_next = 1'b0;
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      open_reg <= 1'b0;
      last_reg <= 3'h0;
    end
    else
    begin
      open_reg <= open_next;
      last_reg <= last_next;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_mux_held: assert property (open_reg |-> $stable(adc_mux_sel))
    else $error("mux moved in conversion");
  a_start_enabled: assert property (adc_start |-> adc_enable)
    else $error("start while disabled");
  a_no_restart: assert property (open_reg && !adc_data_valid |-> !adc_start)
    else $error("second start in conversion");
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start longer than a cycle");
  a_irq_after_done: assert property ($fell(interrupt_request_n) |-> $past(adc_data_valid, 2))
    else $error("irq without result");
  a_irq_clears_go: assert property ($fell(interrupt_request_n) |-> $fell(adc_enable))
    else $error("go kept at irq");
  a_irq_release_read: assert property ($rose(interrupt_request_n) |-> !scl_in)
    else $error("irq freed outside read");
  a_scan_next: assert property (adc_start && $past(adc_data_valid) |->
    adc_mux_sel == ((last_reg == 3'h6) ? 3'h0 : last_reg + 3'h1))
    else $error("scan order broken");
endmodule

bind masc_top masc_top_properties u_props
(
  .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .interrupt_request_n(interrupt_request_n), .adc_enable(adc_enable),
  .input_buffer_disable(input_buffer_disable), .adc_start(adc_start), .adc_mux_sel(adc_mux_sel),
  .adc_data(adc_data), .adc_data_valid(adc_data_valid)
);

// ---- testbench/masc_host_model.sv ----
// Two-wire host model driving register accesses
`timescale 1ns/1ns
`include "masc_consts.svh"
module masc_host_model
(
  // Clock
  input wire logic core_clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  int half = 5;
  logic [6:0] dev_addr = `MASC_I2C_ADDR;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Data moves two cycles after the clock fall, sampled at end of high
  task automatic bit_cycle(input logic b, output logic r);
    tick(2);
    sda_low <= ~b;
    tick(half);
    scl <= 1'b1;
    tick(half);
    r = sda;
    scl <= 1'b0;
  endtask
  // Start or stop: first data level, clock high, then data flips
  task automatic edge_cond(input logic stop);
    tick(2);
    sda_low <= stop;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sda_low <= ~stop;
    tick(half);
    if (!stop)
      scl <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_cycle(d[i], r);
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    edge_cond(1'b0);
    send_byte({dev_addr, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(data, a2);
    edge_cond(1'b1);
    ack = a0 & a1 & a2;
  endtask
  // Single byte read ended by a refusal
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data);
    logic a;
    edge_cond(1'b0);
    send_byte({dev_addr, 1'b0}, a);
    send_byte(ofs, a);
    edge_cond(1'b0);
    send_byte({dev_addr, 1'b1}, a);
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, data[i]);
    bit_cycle(1'b1, a);
    edge_cond(1'b1);
  endtask
  task automatic single_shot(input logic [2:0] ch);
    logic a;
    write_reg(`MASC_OFS_CHANNEL, {2'b00, ch, ch}, a);
    write_reg(`MASC_OFS_CONTROL, 8'h03, a);
  endtask
endmodule

// ---- testbench/masc_top_tb.sv ----
// Testbench for the monitor converter control
`timescale 1ns/1ns
`include "masc_consts.svh"
module masc_top_tb;
  import masc_pkg::*;
  logic core_clk;
  logic rst;
  logic scl;
  logic h_low;
  logic sda;
  logic sda_out;
  logic sda_oe_n;
  logic irq_n;
  logic adc_en;
  logic buf_dis;
  logic adc_start;
  masc_chan_t mux;
  masc_result_t adc_data;
  logic adc_valid;
  logic [7:0] base_v;
  int delay;
  int cnt;
  int starts;
  int num_errors;
  int n_checks;
  masc_result_t exp_res [8];

  assign sda = ~h_low & (sda_oe_n | sda_out);
  masc_top uut (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .interrupt_request_n(irq_n), .adc_enable(adc_en), .input_buffer_disable(buf_dis),
    .adc_start(adc_start), .adc_mux_sel(mux), .adc_data(adc_data), .adc_data_valid(adc_valid));
  masc_host_model host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(h_low));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Front end: result a set delay after each start, noise otherwise
  always @(posedge core_clk)
  begin
    adc_valid <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start)
    begin
      cnt <= delay;
      starts <= starts + 1;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        adc_valid <= 1'b1;
        adc_data <= {1'b1, mux, base_v};
      end
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input string what);
    logic [7:0] d;
    host.read_reg(ofs, d);
    chk(d, exp, what);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 4000 && irq_n !== 1'b0; i++)
      @(posedge core_clk);
    chk_bit(irq_n, 1'b0, "irq");
  endtask

  task automatic t_reset;
    chk_bit(irq_n, 1'b1, "irq idle");
    chk_bit(buf_dis, 1'b0, "buf idle");
    rd(`MASC_OFS_CONTROL, 8'h00, "ctl");
    rd(`MASC_OFS_CHANNEL, 8'h00, "chs");
    rd(`MASC_OFS_RESULT_LOW, 8'h00, "res");
    rd(8'h0b, 8'h00, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_single;
    masc_result_t r;
    logic [7:0] v;
    for (int c = 0; c < 7; c++)
    begin
      v = 8'h3c ^ 8'(c);
      base_v <= v;
      r = {1'b1, 3'(c), v};
      exp_res[c] = r;
      host.single_shot(3'(c));
      wait_irq();
      chk_bit(adc_en, 1'b0, "go clear");
      rd(`MASC_OFS_CONTROL, 8'h02, "ctl go");
      rd(`MASC_OFS_CHANNEL, {2'b10, 3'(c), 3'(c)}, "ready");
      chk_bit(irq_n, 1'b0, "irq held");
      rd(`MASC_OFS_RESULT_HIGH, r[11:4], "hi");
      chk_bit(irq_n, 1'b1, "irq free");
      rd(`MASC_OFS_RESULT_LOW, {4'h0, r[3:0]}, "lo");
      rd(`MASC_OFS_CHANNEL, {2'b00, 3'(c), 3'(c)}, "ready clr");
    end
    $display("t_single done");
  endtask
  task automatic t_retain;
    logic a;
    for (int c = 0; c < 8; c++)
    begin
      host.write_reg(`MASC_OFS_CHANNEL, {2'b00, 3'(c), 3'h0}, a);
      rd(`MASC_OFS_RESULT_HIGH, exp_res[c][11:4], "kept hi");
    end
    $display("t_retain done");
  endtask
  task automatic t_busy;
    int s0;
    logic a;
    host.half = 12;
    delay <= 1500;
    base_v <= 8'hc3;
    s0 = starts;
    host.single_shot(3'h2);
    chk_bit(adc_en, 1'b1, "enabled");
    host.write_reg(`MASC_OFS_CONTROL, 8'h03, a);
    wait_irq();
    chk(8'(starts - s0), 8'h01, "one start");
    rd(`MASC_OFS_RESULT_HIGH, 8'hac, "busy hi");
    host.half = 5;
    delay <= 20;
    $display("t_busy done");
  endtask
  task automatic t_scan;
    int s0;
    logic a;
    logic [7:0] d;
    base_v <= 8'h5e;
    s0 = starts;
    host.write_reg(`MASC_OFS_CONTROL, 8'h05, a);
    d = 8'h00;
    for (int i = 0; i < 10 && d[7] !== 1'b1; i++)
      host.read_reg(`MASC_OFS_CHANNEL, d);
    chk_bit(d[7], 1'b1, "scan ready");
    chk_bit(irq_n, 1'b1, "no irq");
    host.write_reg(`MASC_OFS_CONTROL, 8'h00, a);
    chk_bit(starts - s0 >= 7, 1'b1, "all chans");
    host.write_reg(`MASC_OFS_CHANNEL, {2'b00, 3'h4, 3'h0}, a);
    rd(`MASC_OFS_RESULT_HIGH, 8'hc5, "scan hi");
    // Single and scan both set: no conversion, buffer disable follows bit 3
    s0 = starts;
    host.write_reg(`MASC_OFS_CONTROL, 8'h0f, a);
    chk_bit(buf_dis, 1'b1, "buf set");
    chk_bit(adc_en, 1'b1, "go mixed");
    rd(`MASC_OFS_CONTROL, 8'h0f, "ctl all");
    host.write_reg(`MASC_OFS_CONTROL, 8'h00, a);
    chk(8'(starts - s0), 8'h00, "mixed idle");
    chk_bit(buf_dis, 1'b0, "buf clr");
    $display("t_scan done");
  endtask

  task automatic complete_run;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    adc_data = 12'h000;
    adc_valid = 1'b0;
    base_v = 8'h00;
    delay = 20;
    cnt = 0;
    starts = 0;
    num_errors = 0;
    n_checks = 0;
    exp_res[7] = 12'h000;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    t_reset();
    t_single();
    t_retain();
    t_busy();
    t_scan();
    complete_run();
  end

  initial
  begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
